// File: gpx_pkg.sv
package gpx_pkg;

	// Widths of the two ports, of the register bus and of the change detector
	localparam int PA_W = 5;
	localparam int PB_W = 8;
	localparam int DW = 8;
	localparam int AW = 8;
	localparam int IOC_W = 4;

	// Register addresses
	localparam logic [7:0] ADDR_PORT_A = 8'h05;
	localparam logic [7:0] ADDR_PORT_B = 8'h06;
	localparam logic [7:0] ADDR_INTC_LO = 8'h0B;
	localparam logic [7:0] ADDR_INTC_HI = 8'h8B;
	localparam logic [7:0] ADDR_OPTION = 8'h81;
	localparam logic [7:0] ADDR_DIR_A = 8'h85;
	localparam logic [7:0] ADDR_DIR_B = 8'h86;

	// Reset values
	localparam logic [7:0] RST_OPTION = 8'hFF;
	localparam logic [4:0] RST_DIR_A = 5'h1F;
	localparam logic [7:0] RST_DIR_B = 8'hFF;
	localparam logic [7:0] RST_INTC = 8'h00;
	localparam logic [4:0] RST_LAT_A = 5'h00;
	localparam logic [7:0] RST_LAT_B = 8'h00;
	localparam logic [7:0] RST_RDATA = 8'h00;

	// Field positions
	localparam int BIT_PULLUP_DIS_N = 7;
	localparam int BIT_PORT_CHANGE_FLAG = 0;
	localparam int BIT_PORT_CHANGE_IE = 3;
	localparam int BIT_EXT_IRQ_EN = 4;
	localparam int BIT_OPEN_DRAIN = 4;
	localparam int BIT_EXT_IRQ_PIN = 0;
	localparam int BIT_PROG_CLK = 6;
	localparam int BIT_PROG_DATA = 7;
	localparam int IOC_LO = 4;

	// Whole register state of the port block
	typedef struct packed {
		logic [PA_W-1:0] a_lat;
		logic [PA_W-1:0] a_dir;
		logic a_rz;
		logic [PB_W-1:0] b_lat;
		logic [PB_W-1:0] b_dir;
		logic [DW-1:0] opt;
		logic [DW-1:0] intc;
		logic [DW-1:0] rdata;
		logic wake;
	} gpx_state_t;

	// Bit-modify: masked bits from new data, others from the old value
	function automatic logic [DW-1:0] gpx_merge(input logic [DW-1:0] old_v, input logic [DW-1:0] new_v,
		input logic [DW-1:0] mask);
		gpx_merge = (old_v & ~mask) | (new_v & mask);
	endfunction

endpackage

// File: gpx_sync.sv
`timescale 1ns/1ps
module gpx_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} gpx_sync_t;

	gpx_sync_t st_q;
	gpx_sync_t st_d;

	// Two-stage chain; only the second stage is visible
	always_comb begin
		st_d.s1 = d;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign q = st_q.s2;
endmodule

// File: gpx_ioc.sv
`timescale 1ns/1ps
module gpx_ioc
	import gpx_pkg::*;
#(
	parameter int N = IOC_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [N-1:0] pins,
	input wire logic [N-1:0] dir,
	input wire logic snap,
	output logic mismatch
);
	typedef struct packed {
		logic [N-1:0] old;
	} gpx_ioc_t;

	gpx_ioc_t st_q;
	gpx_ioc_t st_d;

	// Access to the port re-latches the reference value
	always_comb begin
		st_d = st_q;
		if (snap) begin
			st_d.old = pins;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Only inputs compare; mismatches are ORed
	assign mismatch = |((pins ^ st_q.old) & dir);
endmodule

// File: gpx_ports.sv
`timescale 1ns/1ps
module gpx_ports
	import gpx_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	input wire logic [DW-1:0] wr_mask,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [DW-1:0] rdata,
	input wire logic [PA_W-1:0] pa_in,
	output logic [PA_W-1:0] pa_out,
	output logic [PA_W-1:0] pa_oe,
	input wire logic [PB_W-1:0] pb_in,
	output logic [PB_W-1:0] pb_out,
	output logic [PB_W-1:0] pb_oe,
	output logic [PB_W-1:0] pb_pullup,
	output logic [PB_W-1:0] pb_schmitt,
	input wire logic prog_mode_pin,
	input wire logic prog_data_out,
	input wire logic prog_data_oe,
	output logic prog_clk,
	output logic prog_data,
	output logic timer_clk_level,
	output logic external_irq_pin,
	output logic [DW-1:0] option_cfg,
	output logic port_change_irq,
	input wire logic sleep_active,
	output logic wake_req
);

	gpx_state_t st_q;
	gpx_state_t st_d;

	logic [PA_W-1:0] pa_s;
	logic [PB_W-1:0] pb_s;
	logic prog_s;
	logic ioc_mismatch;
	logic pb_snap;
	logic [DW-1:0] a_merged;
	logic [DW-1:0] b_merged;
	logic [DW-1:0] intc_merged;
	logic [DW-1:0] dir_a_merged;

	// Pin levels cross into the clock domain through two flops
	gpx_sync #(
		.W(PA_W + PB_W + 1)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.d({prog_mode_pin, pb_in, pa_in}),
		.q({prog_s, pb_s, pa_s})
	);

	// Any read or write of port B re-latches the change reference
	assign pb_snap = (wr_stb || rd_stb) && (addr == ADDR_PORT_B);

	// Change detector on the upper port B pins that are inputs
	gpx_ioc #(
		.N(IOC_W)
	) u_ioc (
		.clk(clk),
		.rst(rst),
		.pins(pb_s[PB_W-1:IOC_LO]),
		.dir(st_q.b_dir[PB_W-1:IOC_LO]),
		.snap(pb_snap),
		.mismatch(ioc_mismatch)
	);

	// Port writes merge with the sampled pins, not with the latch
	assign a_merged = gpx_merge({3'h0, pa_s}, wdata, wr_mask);
	assign b_merged = gpx_merge(pb_s, wdata, wr_mask);
	assign intc_merged = gpx_merge(st_q.intc, wdata, wr_mask);
	assign dir_a_merged = gpx_merge({3'h0, st_q.a_dir}, wdata, wr_mask);

	// Next state: register writes, flag set, read data, wake
	always_comb begin
		st_d = st_q;
		st_d.rdata = RST_RDATA;
		if (wr_stb) begin
			case (addr)
				ADDR_PORT_A: begin
					st_d.a_lat = a_merged[PA_W-1:0];
					st_d.a_rz = 1'b0;
				end
				ADDR_PORT_B: begin
					st_d.b_lat = b_merged;
				end
				ADDR_INTC_LO, ADDR_INTC_HI: begin
					st_d.intc = intc_merged;
				end
				ADDR_OPTION: begin
					st_d.opt = gpx_merge(st_q.opt, wdata, wr_mask);
				end
				ADDR_DIR_A: begin
					st_d.a_dir = dir_a_merged[PA_W-1:0];
					st_d.a_rz = 1'b0;
				end
				ADDR_DIR_B: begin
					st_d.b_dir = gpx_merge(st_q.b_dir, wdata, wr_mask);
				end
				default: begin
					st_d.a_rz = st_q.a_rz;
				end
			endcase
		end
		// A live mismatch sets the flag and beats a clear
		if (ioc_mismatch) begin
			st_d.intc[BIT_PORT_CHANGE_FLAG] = 1'b1;
		end
		if (rd_stb) begin
			case (addr)
				ADDR_PORT_A: begin
					st_d.rdata = st_q.a_rz ? 8'h00 : {3'h0, pa_s};
				end
				ADDR_PORT_B: begin
					st_d.rdata = pb_s;
				end
				ADDR_INTC_LO, ADDR_INTC_HI: begin
					st_d.rdata = st_q.intc;
				end
				ADDR_OPTION: begin
					st_d.rdata = st_q.opt;
				end
				ADDR_DIR_A: begin
					st_d.rdata = {3'h0, st_q.a_dir};
				end
				ADDR_DIR_B: begin
					st_d.rdata = st_q.b_dir;
				end
				default: begin
					st_d.rdata = RST_RDATA;
				end
			endcase
		end
		// Enabled port change requests wake while asleep
		st_d.wake = sleep_active && st_q.intc[BIT_PORT_CHANGE_FLAG]
			&& st_q.intc[BIT_PORT_CHANGE_IE];
	end

	// State register; ports come up as inputs, pull-ups off
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q.a_lat <= RST_LAT_A;
			st_q.a_dir <= RST_DIR_A;
			st_q.a_rz <= 1'b1;
			st_q.b_lat <= RST_LAT_B;
			st_q.b_dir <= RST_DIR_B;
			st_q.opt <= RST_OPTION;
			st_q.intc <= RST_INTC;
			st_q.rdata <= RST_RDATA;
			st_q.wake <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	// Port A drivers; bit 4 only ever pulls low
	always_comb begin
		pa_out = st_q.a_lat;
		pa_oe = ~st_q.a_dir;
		pa_out[BIT_OPEN_DRAIN] = 1'b0;
		pa_oe[BIT_OPEN_DRAIN] = ~st_q.a_dir[BIT_OPEN_DRAIN] & ~st_q.a_lat[BIT_OPEN_DRAIN];
	end

	// Port B drivers; programming mode takes over bits 6 and 7
	always_comb begin
		pb_out = st_q.b_lat;
		pb_oe = ~st_q.b_dir;
		if (prog_s) begin
			pb_oe[BIT_PROG_CLK] = 1'b0;
			pb_out[BIT_PROG_DATA] = prog_data_out;
			pb_oe[BIT_PROG_DATA] = prog_data_oe;
		end
	end

	// Input buffer type per pin
	always_comb begin
		pb_schmitt = '0;
		pb_schmitt[BIT_EXT_IRQ_PIN] = st_q.intc[BIT_EXT_IRQ_EN];
		pb_schmitt[BIT_PROG_CLK] = prog_s;
		pb_schmitt[BIT_PROG_DATA] = prog_s;
	end

	// Shared pull-up enable, removed on output pins
	assign pb_pullup = {PB_W{~st_q.opt[BIT_PULLUP_DIS_N]}} & st_q.b_dir;

	// Alternate functions seen by neighbouring logic
	assign timer_clk_level = pa_s[BIT_OPEN_DRAIN];
	assign external_irq_pin = pb_s[BIT_EXT_IRQ_PIN];
	assign prog_clk = pb_s[BIT_PROG_CLK];
	assign prog_data = pb_s[BIT_PROG_DATA];

	// Register-sourced outputs
	assign rdata = st_q.rdata;
	assign option_cfg = st_q.opt;
	assign port_change_irq = st_q.intc[BIT_PORT_CHANGE_FLAG] & st_q.intc[BIT_PORT_CHANGE_IE];
	assign wake_req = st_q.wake;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Sequences for a port B read followed by quiet pins, and for a port A write
	sequence s_pb_read;
		rd_stb && addr == ADDR_PORT_B;
	endsequence

	sequence s_pins_hold;
		$stable(pb_s[PB_W-1:IOC_LO]);
	endsequence

	sequence s_pa_write;
		wr_stb && addr == ADDR_PORT_A;
	endsequence

	property p_read_quiets;
		s_pb_read ##1 s_pins_hold |-> !ioc_mismatch;
	endproperty

	property p_pa_rmw;
		s_pa_write |=> st_q.a_lat == (($past(pa_s) & ~$past(wr_mask[PA_W-1:0]))
			| ($past(wdata[PA_W-1:0]) & $past(wr_mask[PA_W-1:0])));
	endproperty

	a_pa_rmw_latch: assert property (p_pa_rmw)
		else $error("port A latch not loaded from pins and write data");

	a_dir_drive: assert property (wr_stb && addr == ADDR_DIR_A && wr_mask == 8'hFF
		|=> pa_oe[3:0] == ~$past(wdata[3:0]))
		else $error("port A drivers do not follow direction write");

	a_open_drain: assert property (pa_oe[BIT_OPEN_DRAIN]
		|-> !st_q.a_lat[BIT_OPEN_DRAIN] && !st_q.a_dir[BIT_OPEN_DRAIN] && !pa_out[BIT_OPEN_DRAIN])
		else $error("open drain pin driven high or as input");

	a_upper_zero: assert property (rd_stb && (addr == ADDR_PORT_A || addr == ADDR_DIR_A)
		|=> rdata[7:5] == 3'h0)
		else $error("unimplemented port A bits read nonzero");

	a_reset_state: assert property ($past(rst) |-> pb_pullup == 8'h00 && pa_oe == 5'h00)
		else $error("pins not inputs or pull-ups on after reset");

	a_pullup_write: assert property (wr_stb && addr == ADDR_OPTION && wr_mask[BIT_PULLUP_DIS_N]
		&& !wdata[BIT_PULLUP_DIS_N] && !(wr_stb && addr == ADDR_DIR_B)
		|=> pb_pullup == st_q.b_dir)
		else $error("pull-ups do not follow input pins after enable");

	a_flag_set: assert property (ioc_mismatch |=> st_q.intc[BIT_PORT_CHANGE_FLAG])
		else $error("change flag not set by mismatch");

	a_read_quiets: assert property (p_read_quiets)
		else $error("mismatch persists after port B read");

	a_alias_write: assert property (wr_stb && addr == ADDR_INTC_HI && wr_mask == 8'hFF
		|=> st_q.intc[7:1] == $past(wdata[7:1]))
		else $error("upper interrupt control address misses storage");

	a_wake_path: assert property (ioc_mismatch && sleep_active && st_q.intc[BIT_PORT_CHANGE_IE]
		&& !(wr_stb && (addr == ADDR_INTC_LO || addr == ADDR_INTC_HI)) ##1 sleep_active
		|=> wake_req)
		else $error("port change did not wake the sleeping core");

	a_read_once: assert property (!rd_stb |=> rdata == 8'h00)
		else $error("read data stands beyond one cycle");

	// Full direction write on port B, then no programming takeover
	sequence s_dir_b_full;
		wr_stb && addr == ADDR_DIR_B && wr_mask == 8'hFF;
	endsequence

	property p_pb_dir_drive;
		s_dir_b_full ##1 !prog_s |-> pb_oe == ~$past(wdata);
	endproperty

	a_pb_dir_drive: assert property (p_pb_dir_drive)
		else $error("port B drivers do not follow direction write");

	// Port B data path
	a_pb_read_data: assert property (rd_stb && addr == ADDR_PORT_B |=> rdata == $past(pb_s))
		else $error("port B read does not return pin levels");

	a_pb_rmw: assert property (wr_stb && addr == ADDR_PORT_B |=> st_q.b_lat == (($past(pb_s) & ~$past(wr_mask))
		| ($past(wdata) & $past(wr_mask))))
		else $error("port B latch not loaded from pins and write data");

	// Pull-ups never fight a driven pin on bits 0 to 6 and stay off while disabled
	a_pullup_output: assert property ((pb_pullup & pb_oe & 8'h7F) == 8'h00)
		else $error("pull-up left on a driven pin");

	a_pullup_off: assert property (option_cfg[BIT_PULLUP_DIS_N] |-> pb_pullup == 8'h00)
		else $error("pull-ups on while control bit set");

	// Change detection ignores pins that are outputs
	a_ioc_exclude: assert property (st_q.b_dir[PB_W-1:IOC_LO] == 4'h0 |-> !ioc_mismatch)
		else $error("output pin took part in change detection");

	a_prog_takeover: assert property (prog_s |-> !pb_oe[BIT_PROG_CLK]
		&& pb_oe[BIT_PROG_DATA] == prog_data_oe && pb_schmitt[BIT_PROG_DATA:BIT_PROG_CLK] == 2'b11)
		else $error("programming mode does not own bits 6 and 7");

	a_schmitt_irq: assert property (wr_stb && addr == ADDR_INTC_LO && wr_mask == 8'hFF
		|=> pb_schmitt[BIT_EXT_IRQ_PIN] == $past(wdata[BIT_EXT_IRQ_EN]))
		else $error("interrupt pin buffer does not follow its enable");

	a_wake_asleep: assert property (wake_req |-> $past(sleep_active))
		else $error("wake request while core awake");

	a_pa_read_zero: assert property (rd_stb && addr == ADDR_PORT_A && st_q.a_rz
		|=> rdata == 8'h00)
		else $error("port A read nonzero before first write");

	a_dir_a_write: assert property (wr_stb && addr == ADDR_DIR_A |=> st_q.a_dir == (($past(st_q.a_dir)
		& ~$past(wr_mask[PA_W-1:0])) | ($past(wdata[PA_W-1:0]) & $past(wr_mask[PA_W-1:0]))))
		else $error("port A direction write lost bits");

	// Flag is cleared only by a write to interrupt control
	a_flag_sticky: assert property (st_q.intc[BIT_PORT_CHANGE_FLAG]
		&& !(wr_stb && (addr == ADDR_INTC_LO || addr == ADDR_INTC_HI)) |=> st_q.intc[BIT_PORT_CHANGE_FLAG])
		else $error("change flag dropped without a clear");

	a_irq_enable: assert property (port_change_irq |-> st_q.intc[BIT_PORT_CHANGE_IE])
		else $error("change request raised while disabled");

endmodule

// File: gpx_pins.sv
`timescale 1ns/1ps
module gpx_pins
	import gpx_pkg::*;
(
	input wire logic clk,
	input wire logic [PA_W-1:0] pa_out,
	input wire logic [PA_W-1:0] pa_oe,
	input wire logic [PB_W-1:0] pb_out,
	input wire logic [PB_W-1:0] pb_oe,
	input wire logic [PB_W-1:0] pb_pullup,
	input wire logic [PA_W-1:0] ext_a,
	input wire logic [PB_W-1:0] ext_b,
	input wire logic [PB_W-1:0] ext_en,
	output logic [PA_W-1:0] pa_in,
	output logic [PB_W-1:0] pb_in
);
	logic [PB_W-1:0] last_q;
	// Wire levels; a floating line shows the inverse of its last level
	always_comb begin
		for (int i = 0; i < PA_W; i++) begin
			pa_in[i] = pa_oe[i] ? pa_out[i] : ext_a[i];
		end
		for (int i = 0; i < PB_W; i++) begin
			if (pb_oe[i]) begin
				pb_in[i] = pb_out[i];
			end else if (ext_en[i]) begin
				pb_in[i] = ext_b[i];
			end else if (pb_pullup[i]) begin
				pb_in[i] = 1'b1;
			end else begin
				pb_in[i] = ~last_q[i];
			end
		end
	end
	// Last seen level of each port B line
	always_ff @(posedge clk) begin
		last_q <= pb_in;
	end
endmodule

// File: dual_gpio_ports_pullup_ioc_tb.sv
`timescale 1ns/1ps
module dual_gpio_ports_pullup_ioc_tb
	import gpx_pkg::*;
;
	logic clk = 0, rst = 1, wr_stb = 0, rd_stb = 0;
	logic prog_mode_pin = 0, prog_data_out = 0, prog_data_oe = 0, sleep_active = 0;
	logic [7:0] addr = 0, wdata = 0, wr_mask = 0, rdata, option_cfg;
	logic [PA_W-1:0] pa_in, pa_out, pa_oe, ext_a = 5'h0C;
	logic [PB_W-1:0] pb_in, pb_out, pb_oe, pb_pullup, pb_schmitt, ext_b = 8'hA5, ext_en = 8'hFF;
	logic prog_clk, prog_data, timer_clk_level, external_irq_pin, port_change_irq, wake_req;
	int err_total = 0, tests_run = 0;
	logic [15:0] rows [8] = '{{ADDR_OPTION, 8'hFF}, {ADDR_DIR_A, 8'h1F}, {ADDR_DIR_B, 8'hFF},
		{ADDR_INTC_LO, 8'h01}, {ADDR_INTC_HI, 8'h01}, {ADDR_PORT_A, 8'h00}, {ADDR_PORT_B, 8'hA5}, {8'h07, 8'h00}};
	// Change flag catches the pins settling against the cleared reference

	// 40 MHz clock
	always #12.5 clk = ~clk;

	gpx_ports gpx_ports_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_mask(wr_mask),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
		.pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .pb_pullup(pb_pullup), .pb_schmitt(pb_schmitt),
		.prog_mode_pin(prog_mode_pin), .prog_data_out(prog_data_out), .prog_data_oe(prog_data_oe),
		.prog_clk(prog_clk), .prog_data(prog_data), .timer_clk_level(timer_clk_level),
		.external_irq_pin(external_irq_pin), .option_cfg(option_cfg), .port_change_irq(port_change_irq),
		.sleep_active(sleep_active), .wake_req(wake_req));

	gpx_pins gpx_pins_i (.clk(clk), .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe),
		.pb_pullup(pb_pullup), .ext_a(ext_a), .ext_b(ext_b), .ext_en(ext_en), .pa_in(pa_in), .pb_in(pb_in));

	task automatic print_verdict();
		$display("errors %0d of %0d comparisons", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_mask <= m;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
		#1;
	endtask

	// One-cycle read strobe; data stands in the next cycle only
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1;
		chk(rdata, e);
	endtask

	// Hang guard
	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		print_verdict();
	end

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		tick(3);
		chk(pb_pullup, 8'h00);
		chk(pa_oe, 5'h00);
		chk(pb_oe, 8'h00);
		for (int i = 0; i < 8; i++) begin
			rd(rows[i][15:8], rows[i][7:0]);
		end
		// Port A: read-modify-write takes unmasked bits from the pins
		wr(ADDR_PORT_A, 8'h01, 8'h03);
		rd(ADDR_PORT_A, 8'h0C);
		wr(ADDR_DIR_A, 8'h00, 8'hFF);
		chk(pa_out, 5'h0D);
		chk(pa_oe, 5'h1F);
		wr(ADDR_PORT_A, 8'hFF, 8'hFF);
		chk(pa_oe, 5'h0F);
		chk(pa_out, 5'h0F);
		wr(ADDR_DIR_A, 8'hFF, 8'hFF);
		rd(ADDR_DIR_A, 8'h1F);
		@(posedge clk);
		ext_a <= 5'h1C;
		tick(4);
		chk(timer_clk_level, 8'h01);
		rd(ADDR_PORT_A, 8'h1C);
		// Port B direction, pull-ups and latch
		wr(ADDR_OPTION, 8'h7F, 8'hFF);
		chk(option_cfg, 8'h7F);
		wr(ADDR_DIR_B, 8'hF0, 8'hFF);
		chk(pb_pullup, 8'hF0);
		chk(pb_oe, 8'h0F);
		wr(ADDR_PORT_B, 8'h3C, 8'hFF);
		chk(pb_out, 8'h3C);
		tick(3);
		rd(ADDR_PORT_B, 8'hAC);
		// Change on an upper input sets the flag, wakes, and holds
		wr(ADDR_INTC_HI, 8'h08, 8'hFF);
		@(posedge clk);
		ext_b <= 8'h85;
		tick(5);
		chk(port_change_irq, 8'h01);
		@(posedge clk);
		sleep_active <= 1'b1;
		tick(2);
		chk(wake_req, 8'h01);
		@(posedge clk);
		sleep_active <= 1'b0;
		wr(ADDR_INTC_LO, 8'h00, 8'h01);
		rd(ADDR_INTC_LO, 8'h09);
		rd(ADDR_PORT_B, 8'h8C);
		wr(ADDR_INTC_LO, 8'h00, 8'h01);
		rd(ADDR_INTC_HI, 8'h08);
		chk(port_change_irq, 8'h00);
		// An upper pin turned output is left out of the comparison
		wr(ADDR_DIR_B, 8'h70, 8'hFF);
		chk(pb_pullup, 8'h70);
		tick(5);
		rd(ADDR_INTC_LO, 8'h08);
		wr(ADDR_INTC_LO, 8'h18, 8'hFF);
		chk(pb_schmitt, 8'h01);
		chk(external_irq_pin, 8'h00);
		// Serial programming mode on bits 6 and 7
		@(posedge clk);
		prog_mode_pin <= 1'b1;
		prog_data_oe <= 1'b1;
		prog_data_out <= 1'b1;
		tick(5);
		chk(pb_schmitt, 8'hC1);
		chk(pb_oe, 8'h8F);
		chk(pb_out, 8'hBC);
		chk({prog_clk, prog_data}, 8'h01);
		// Mid-run reset brings every pin back to input, pull-ups off
		@(posedge clk);
		rst <= 1'b1;
		prog_mode_pin <= 1'b0;
		tick(3);
		@(posedge clk);
		rst <= 1'b0;
		tick(3);
		chk(option_cfg, 8'hFF);
		chk(pb_pullup, 8'h00);
		chk(pa_oe, 5'h00);
		chk(pb_oe, 8'h00);
		chk(wake_req, 8'h00);
		rd(ADDR_PORT_A, 8'h00);
		rd(ADDR_DIR_B, 8'hFF);
		print_verdict();
	end
endmodule
